// >>> common/saext_defines.vh
`ifndef SAEXT_DEFINES_VH
`define SAEXT_DEFINES_VH
`define SAEXT_STEPS_8      5'h08
`define SAEXT_STEPS_16     5'h10
`define SAEXT_MAX_RATE_HZ  32'h000003E8
`define SAEXT_CLK_HZ       32'h05F5E100
`define SAEXT_MIN_PERIOD   (`SAEXT_CLK_HZ / `SAEXT_MAX_RATE_HZ)
`define SAEXT_RESET_ADDR   4'h0
`endif

// >>> hdl/saext_sync.v
module saext_sync #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         rst,
  input  wire [W-1:0] din,
  output wire [W-1:0] dout
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end
  assign dout = sync_q;
endmodule

// >>> hdl/saext_top.v
`include "saext_defines.vh"
module saext_top #(
  parameter MIN_PERIOD = `SAEXT_MIN_PERIOD
) (
  input  wire       CLOCK,
  input  wire       SYS_RST,
  input  wire       STEP_CLK,
  input  wire       START_IN,
  input  wire       STOP_IN,
  input  wire       RESET_IN,
  input  wire       MODE_16,
  input  wire       OWN_SWITCH,
  input  wire       OWN_EXT,
  input  wire [3:0] FIRST_STEP,
  input  wire [3:0] LAST_STEP,
  output reg        STEP_ADDR_BIT0,
  output reg        STEP_ADDR_BIT1,
  output reg        STEP_ADDR_BIT2,
  output reg        UPPER_HALF_BIT,
  output reg        UPPER_HALF_LED,
  output reg        OWNER,
  output reg        RUNNING,
  output reg        RATE_OVER
);
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  wire [5:0] s;
  wire [8:0] cfg_s;
  saext_sync #(.W(6)) u_sync (
    .clk  (CLOCK),
    .rst  (SYS_RST),
    .din  ({STEP_CLK, START_IN, STOP_IN, RESET_IN, OWN_SWITCH, OWN_EXT}),
    .dout (s)
  );
  // switch levels are slow, but still come from outside the clock
  saext_sync #(.W(9)) u_sync_cfg (
    .clk  (CLOCK),
    .rst  (SYS_RST),
    .din  ({MODE_16, FIRST_STEP, LAST_STEP}),
    .dout (cfg_s)
  );
  wire       mode16    = cfg_s[8];
  wire [3:0] first_raw = cfg_s[7:4];
  wire [3:0] last_raw  = cfg_s[3:0];

  // ----------------------------------------
  // edge detection
  // ----------------------------------------
  // control pins idle low, so a zero reset gives no false edge
  reg  [3:0] prev_q;
  wire       clk_rise   = s[5] & ~prev_q[3];
  wire       start_rise = s[4] & ~prev_q[2];
  wire       stop_rise  = s[3] & ~prev_q[1];
  wire       rst_rise   = s[2] & ~prev_q[0];
  always @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      prev_q <= 4'h0;
    end else begin
      prev_q <= s[5:2];
    end
  end

  // ----------------------------------------
  // range helpers
  // ----------------------------------------
  // fold a 0-based index into the active range
  function [3:0] clip;
    input [3:0] v;
    input       m16;
    begin
      clip = m16 ? v : {1'b0, v[2:0]};
    end
  endfunction

  wire [3:0] first_i = clip(first_raw, mode16);
  wire [3:0] last_i  = clip(last_raw, mode16);

  // ----------------------------------------
  // run state
  // ----------------------------------------
  localparam ST_STOPPED = 1'b0;
  localparam ST_RUN     = 1'b1;
  reg        run_q;
  reg        run_d;
  always @* begin
    run_d = run_q;
    case (run_q)
      ST_STOPPED: begin
        if (start_rise && !stop_rise)
          run_d = ST_RUN;
      end
      ST_RUN: begin
        if (stop_rise)
          run_d = ST_STOPPED;
      end
      default: begin
        run_d = ST_STOPPED;
      end
    endcase
  end
  always @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      run_q <= ST_STOPPED;
    end else begin
      run_q <= run_d;
    end
  end

  // step edges are refused while stopped
  wire       step_take = clk_rise & run_q;

  // ----------------------------------------
  // reset arming
  // ----------------------------------------
  // a request in the cycle of a taken step wins, so it is never lost
  reg        arm_q;
  reg        arm_d;
  always @* begin
    arm_d = arm_q;
    if (step_take)
      arm_d = 1'b0;
    if (rst_rise)
      arm_d = 1'b1;
  end
  always @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      arm_q <= 1'b0;
    end else begin
      arm_q <= arm_d;
    end
  end

  // ----------------------------------------
  // step position
  // ----------------------------------------
  reg  [3:0] pos_q;
  reg  [3:0] pos_d;
  always @* begin
    pos_d = pos_q;
    if (step_take) begin
      if (arm_q)
        pos_d = first_i;
      else if (last_i <= first_i)
        pos_d = first_i;
      else if (pos_q >= last_i || pos_q < first_i)
        pos_d = first_i;
      else
        pos_d = pos_q + 4'h1;
    end
    // upper half never reachable in 8-step mode
    if (!mode16)
      pos_d[3] = 1'b0;
  end
  always @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pos_q <= `SAEXT_RESET_ADDR;
    end else begin
      pos_q <= pos_d;
    end
  end

  // ----------------------------------------
  // step rate monitor
  // ----------------------------------------
  // faster steps than the rated limit are flagged, not refused
  localparam GAP_MAX = 32'hFFFFFFFF;
  reg [31:0] gap_q;
  reg [31:0] gap_d;
  reg        over_d;
  always @* begin
    gap_d  = gap_q;
    over_d = RATE_OVER;
    if (gap_q != GAP_MAX)
      gap_d = gap_q + 32'h1;
    if (clk_rise) begin
      over_d = (gap_q < MIN_PERIOD);
      gap_d  = 32'h0;
    end
  end
  always @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      gap_q     <= 32'h0;
      RATE_OVER <= 1'b0;
    end else begin
      gap_q     <= gap_d;
      RATE_OVER <= over_d;
    end
  end

  // ----------------------------------------
  // address outputs
  // ----------------------------------------
  always @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      STEP_ADDR_BIT0 <= 1'b0;
      STEP_ADDR_BIT1 <= 1'b0;
      STEP_ADDR_BIT2 <= 1'b0;
      UPPER_HALF_BIT <= 1'b0;
      UPPER_HALF_LED <= 1'b0;
    end else begin
      STEP_ADDR_BIT0 <= pos_q[0];
      STEP_ADDR_BIT1 <= pos_q[1];
      STEP_ADDR_BIT2 <= pos_q[2];
      UPPER_HALF_BIT <= mode16 & pos_q[3];
      UPPER_HALF_LED <= mode16 & pos_q[3];
    end
  end

  // ----------------------------------------
  // status outputs
  // ----------------------------------------
  always @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      OWNER   <= 1'b0;
      RUNNING <= 1'b0;
    end else begin
      // low owner hands both slaves to the first slave's own controller
      OWNER   <= s[1] | s[0];
      RUNNING <= run_q;
    end
  end
endmodule

// >>> sim/saext_slave.sv
module saext_slave (
  input  wire       b0,
  input  wire       b1,
  input  wire       b2,
  output wire [7:0] lit
);
  timeunit 1ns;
  timeprecision 1ps;
  // no own controller input: it never steps alone
  assign lit = 8'h01 << {b2, b1, b0};
endmodule

// >>> sim/saext_asserts.sv
module saext_asserts (
  input wire       CLOCK,
  input wire       SYS_RST,
  input wire       START_IN,
  input wire       STOP_IN,
  input wire       MODE_16,
  input wire       OWN_SWITCH,
  input wire       OWN_EXT,
  input wire [3:0] FIRST_STEP,
  input wire [3:0] LAST_STEP,
  input wire       STEP_ADDR_BIT0,
  input wire       STEP_ADDR_BIT1,
  input wire       STEP_ADDR_BIT2,
  input wire       UPPER_HALF_BIT,
  input wire       UPPER_HALF_LED,
  input wire       OWNER,
  input wire       RUNNING
);
  timeunit 1ns;
  timeprecision 1ps;
  wire [3:0] a4 = {UPPER_HALF_BIT, STEP_ADDR_BIT2, STEP_ADDR_BIT1, STEP_ADDR_BIT0};
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  sequence s_moved; $changed(a4); endsequence
  sequence s_go; $rose(START_IN); endsequence
  a_led_follows: assert property (UPPER_HALF_LED == UPPER_HALF_BIT) else $error("led");
  a_mode8_low: assert property (!MODE_16 [*4] |-> !UPPER_HALF_BIT) else $error("upper");
  a_owner_or: assert property (OWNER == $past(OWN_SWITCH | OWN_EXT, 3)) else $error("own");
  a_start_runs: assert property (s_go |-> ##[1:8] RUNNING) else $error("start");
  a_stop_halts: assert property ($rose(STOP_IN) |-> ##[1:8] !RUNNING) else $error("stop");
  a_stopped_hold: assert property (!RUNNING [*4] |-> $stable(a4)) else $error("hold");
  a_single_step: assert property (s_moved ##0 (!MODE_16 && LAST_STEP[2:0] <= FIRST_STEP[2:0])
    |-> a4 == {1'b0, FIRST_STEP[2:0]}) else $error("single");
  a_range_16: assert property (s_moved ##0 (MODE_16 && FIRST_STEP < LAST_STEP)
    |-> a4 >= FIRST_STEP && a4 <= LAST_STEP) else $error("range");
  a_next_step: assert property (s_moved ##0 MODE_16
    |-> a4 == $past(a4) + 4'h1 || a4 == FIRST_STEP) else $error("next");
endmodule

// >>> sim/step_address_extender_tb.sv
module step_address_extender_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, stp = 0, m16 = 1, sw = 0, ex = 0;
  logic [2:0] ctl = 3'h0;
  logic [3:0] fs = 4'h2, ls = 4'hD;
  wire b0, b1, b2, up, led, own, run, ovr;
  wire [7:0] lit;
  int n_fail = 0, checks_done = 0;
  saext_top #(.MIN_PERIOD(20)) dut (.CLOCK(clk), .SYS_RST(rst), .STEP_CLK(stp),
    .START_IN(ctl[0]), .STOP_IN(ctl[1]), .RESET_IN(ctl[2]), .MODE_16(m16), .OWN_SWITCH(sw),
    .OWN_EXT(ex), .FIRST_STEP(fs), .LAST_STEP(ls), .STEP_ADDR_BIT0(b0), .STEP_ADDR_BIT1(b1),
    .STEP_ADDR_BIT2(b2), .UPPER_HALF_BIT(up), .UPPER_HALF_LED(led), .OWNER(own),
    .RUNNING(run), .RATE_OVER(ovr));
  saext_slave sl (.b0(b0), .b1(b1), .b2(b2), .lit(lit));
  initial forever #5 clk = ~clk;
  task automatic cyc(input int n); repeat (n) @(posedge clk); #1; endtask
  task automatic cmp(input [7:0] got, input [7:0] exp);
    checks_done++;
    if (got !== exp) begin n_fail++; $display("BAD %0t got %h exp %h", $time, got, exp); end
  endtask
  task automatic chk(input [3:0] e);
    cmp({up, b2, b1, b0}, e); cmp(lit, 8'h01 << e[2:0]); cmp(led, e[3]);
  endtask
  task automatic finish_test;
    $display("n_fail %0d checks_done %0d", n_fail, checks_done);
    if (n_fail == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // pulses held for several cycles so the synchronisers see them
  task automatic pul(input [2:0] m); ctl = m; cyc(4); ctl = 3'h0; cyc(8); endtask
  task automatic stepn(input int n); repeat (n) begin stp = 1; cyc(4); stp = 0; cyc(21); end
  endtask
  task automatic go;
    pul(3'h1);
    for (int i = 0; i < 20 && run !== 1'b1; i++) cyc(1);
    cmp(run, 1);
    if (run !== 1'b1) finish_test;
  endtask
  initial begin
    cyc(8); rst = 0; cyc(2);
    stepn(1); chk(4'h0);
    go();
    stepn(1); chk(4'h2);
    stepn(6); chk(4'h8);
    stepn(5); chk(4'hD);
    stepn(1); chk(4'h2);
    stepn(1); pul(3'h4); chk(4'h3);
    stepn(1); chk(4'h2);
    pul(3'h2); cmp(run, 0);
    stepn(1); chk(4'h2);
    for (int i = 0; i < 4; i++) begin {sw, ex} = i[1:0]; cyc(6); cmp(own, i != 0); end
    {sw, ex} = 2'h0; cyc(6);
    rst = 1; m16 = 0; fs = 4'hA; ls = 4'h1; cyc(8); rst = 0; cyc(2);
    go(); stepn(3); chk(4'h2);
    repeat (2) begin stp = 1; cyc(2); stp = 0; cyc(3); end
    cyc(4); cmp(ovr, 1);
    cyc(20); stepn(1); cmp(ovr, 0);
    finish_test();
  end
endmodule
bind saext_top saext_asserts u_chk (.*);
